// file: logic/nfhc_host.sv
// host-side controller that drives the nand pin interface
// What this block does
// - three address cycles: column, row low, row high
// - upper data lines low during address
// - erase sends two row cycles only
// - write strobe pulsed low, chip select low
// - two-cycle ops start on confirm command
// - only reset/status commands accepted while busy
// - undefined commands never issued
// - word-wide data moves sixteen bits
// - read/program: command then three addresses
// - address latch or command latch qualifies byte
`timescale 1ns/1ps
`default_nettype none
`include "nfhc_regs.svh"
module nfhc_host (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire nfhc_pkg::nfhc_req_t i_req,
  input  wire logic              i_req_valid,
  input  wire logic              i_lock_autoread_enable,
  input  wire logic              i_write_protect_n,
  input  wire logic              I_RB_N,
  input  wire logic [15:0]       I_IO,
  output logic                   o_req_ready,
  output logic                   o_req_reject,
  output logic [15:0]            o_rd_data,
  output logic                   o_rd_valid,
  output logic                   o_busy,
  output logic [15:0]            O_IO,
  output logic                   O_IO_OE,
  output logic                   O_CLE,
  output logic                   O_ALE,
  output logic                   O_CE_N,
  output logic                   O_WE_N,
  output logic                   O_READ_STROBE_N,
  output logic                   O_WP_N,
  output logic                   O_LOCK_AUTOREAD_ENABLE
);
  // ==========================================================
  // pin synchronisers
  logic        rb_meta_reg;
  logic        rb_sync_reg;
  logic [15:0] io_meta_reg;
  logic [15:0] io_sync_reg;
  always_ff @(posedge I_CLK) begin
    rb_meta_reg <= I_RB_N;
    rb_sync_reg <= rb_meta_reg;
    io_meta_reg <= I_IO;
    io_sync_reg <= io_meta_reg;
  end
  // ==========================================================
  // command screening
  function automatic logic cmd_legal(input logic [7:0] c);
    cmd_legal = (c == `NFHC_CMD_READ_A)  || (c == `NFHC_CMD_READ_B) ||
                (c == `NFHC_CMD_READ_SPARE) || (c == `NFHC_CMD_READ_ID) ||
                (c == `NFHC_CMD_RESET)   || (c == `NFHC_CMD_STATUS) ||
                (c == `NFHC_CMD_LOCK)    || (c == `NFHC_CMD_LOCK_TIGHT) ||
                (c == `NFHC_CMD_LOCK_STATUS) || (c == `NFHC_CMD_PROG) ||
                (c == `NFHC_CMD_PROG_GO) || (c == `NFHC_CMD_COPY_GO) ||
                (c == `NFHC_CMD_ERASE)   || (c == `NFHC_CMD_ERASE_GO) ||
                (c == `NFHC_CMD_UNLOCK)  || (c == `NFHC_CMD_UNLOCK_GO);
  endfunction : cmd_legal
  function automatic logic cmd_busy_ok(input logic [7:0] c);
    cmd_busy_ok = (c == `NFHC_CMD_RESET) || (c == `NFHC_CMD_STATUS);
  endfunction : cmd_busy_ok
  wire logic       dev_busy    = ~rb_sync_reg;
  wire logic [7:0] req_cmd     = i_req.data[7:0];
  wire logic       is_cmd      = (i_req.op == nfhc_pkg::NFHC_OP_CMD);
  wire logic       cmd_bad     = is_cmd && (!cmd_legal(req_cmd) || (dev_busy && !cmd_busy_ok(req_cmd)));
  // waits and reads stay open while busy, new address or data bytes do not
  wire logic       other_busy  = dev_busy &&
                                 ((i_req.op == nfhc_pkg::NFHC_OP_ADDR) || (i_req.op == nfhc_pkg::NFHC_OP_WR));
  wire logic       wr_blocked  = is_cmd && !i_write_protect_n &&
                                 ((req_cmd == `NFHC_CMD_PROG_GO) || (req_cmd == `NFHC_CMD_ERASE_GO) ||
                                  (req_cmd == `NFHC_CMD_COPY_GO));
  wire logic       req_reject  = cmd_bad || other_busy || wr_blocked;
  // ==========================================================
  // strobe sequencer
  nfhc_pkg::nfhc_state_t state_reg;
  nfhc_pkg::nfhc_state_t state_next;
  nfhc_pkg::nfhc_op_t    op_reg;
  logic [15:0]           data_reg;
  logic [`NFHC_CNT_W-1:0] cnt_reg;
  wire logic             cnt_done = (cnt_reg == `NFHC_CNT_W'(`NFHC_PHASE_CYC - 1));
  wire logic             take     = (state_reg == nfhc_pkg::NFHC_S_IDLE) && i_req_valid;
  wire logic             accept   = take && !req_reject;
  // op owning the coming cycle: the offered one on a take, else the held one
  wire nfhc_pkg::nfhc_op_t cur_op = take ? i_req.op : op_reg;
  wire logic             is_read  = (cur_op == nfhc_pkg::NFHC_OP_RD);
  wire logic             is_wait  = (cur_op == nfhc_pkg::NFHC_OP_WAIT);
  // address bytes use only the low eight lines, upper ones held low
  wire logic [15:0]      drive_val = (op_reg == nfhc_pkg::NFHC_OP_WR) ? data_reg :
                                     {8'h00, data_reg[7:0]};
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      nfhc_pkg::NFHC_S_IDLE: begin
        if (accept) begin
          state_next = (i_req.op == nfhc_pkg::NFHC_OP_WAIT) ? nfhc_pkg::NFHC_S_WAIT : nfhc_pkg::NFHC_S_LOW;
        end
      end
      nfhc_pkg::NFHC_S_LOW: begin
        if (cnt_done) begin
          state_next = nfhc_pkg::NFHC_S_HIGH;
        end
      end
      nfhc_pkg::NFHC_S_HIGH: begin
        if (cnt_done) begin
          state_next = nfhc_pkg::NFHC_S_DONE;
        end
      end
      nfhc_pkg::NFHC_S_WAIT: begin
        if (!dev_busy) begin
          state_next = nfhc_pkg::NFHC_S_DONE;
        end
      end
      nfhc_pkg::NFHC_S_DONE: begin
        state_next = nfhc_pkg::NFHC_S_IDLE;
      end
      default: begin
        state_next = nfhc_pkg::NFHC_S_IDLE;
      end
    endcase
  end
  wire logic phase_step = (state_reg == nfhc_pkg::NFHC_S_LOW) || (state_reg == nfhc_pkg::NFHC_S_HIGH);
  wire logic in_low     = (state_next == nfhc_pkg::NFHC_S_LOW);
  wire logic drive_now  = (state_next == nfhc_pkg::NFHC_S_LOW || state_next == nfhc_pkg::NFHC_S_HIGH) && !is_read;
  wire logic rd_take    = is_read && (state_reg == nfhc_pkg::NFHC_S_LOW) && cnt_done;
  // ==========================================================
  // next pin values
  // chip select stays high through a busy wait
  wire logic        ce_n_next = !((state_next != nfhc_pkg::NFHC_S_IDLE) && !is_wait);
  wire logic        cle_next  = drive_now && (cur_op == nfhc_pkg::NFHC_OP_CMD);
  // address bytes go out in the order queued: column, row low, row high
  wire logic        ale_next  = drive_now && (cur_op == nfhc_pkg::NFHC_OP_ADDR);
  wire logic        we_n_next = !(in_low && !is_read);
  wire logic        rs_n_next = !(in_low && is_read);
  wire logic [15:0] io_next   = !accept ? drive_val :
                                (i_req.op == nfhc_pkg::NFHC_OP_WR) ? i_req.data :
                                {8'h00, i_req.data[7:0]};
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg <= nfhc_pkg::NFHC_S_IDLE;
      op_reg    <= nfhc_pkg::NFHC_OP_CMD;
      data_reg  <= 16'h0000;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        op_reg   <= i_req.op;
        data_reg <= i_req.data;
      end
      cnt_reg <= (phase_step && !cnt_done) ? cnt_reg + 1'b1 : '0;
    end
  end
  // ==========================================================
  // pin registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_CE_N          <= 1'b1;
      O_CLE           <= 1'b0;
      O_ALE           <= 1'b0;
      O_WE_N          <= 1'b1;
      O_READ_STROBE_N <= 1'b1;
      O_IO            <= 16'h0000;
      O_IO_OE         <= 1'b0;
    end else begin
      O_CE_N          <= ce_n_next;
      O_CLE           <= cle_next;
      O_ALE           <= ale_next;
      O_WE_N          <= we_n_next;
      O_READ_STROBE_N <= rs_n_next;
      O_IO            <= io_next;
      O_IO_OE         <= drive_now;
    end
  end
  // ==========================================================
  // handshake and status outputs
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      o_req_ready            <= 1'b0;
      o_req_reject           <= 1'b0;
      o_rd_data              <= 16'h0000;
      o_rd_valid             <= 1'b0;
      o_busy                 <= 1'b0;
      O_WP_N                 <= 1'b0;
      O_LOCK_AUTOREAD_ENABLE <= 1'b0;
    end else begin
      o_req_ready            <= (state_next == nfhc_pkg::NFHC_S_IDLE);
      o_req_reject           <= take && req_reject;
      o_rd_valid             <= rd_take;
      if (rd_take) begin
        o_rd_data <= io_sync_reg;
      end
      o_busy                 <= dev_busy;
      O_WP_N                 <= i_write_protect_n;
      O_LOCK_AUTOREAD_ENABLE <= i_lock_autoread_enable;
    end
  end
endmodule : nfhc_host
`default_nettype wire

// file: inc/nfhc_regs.svh
// timing counts and command codes for the nand host controller
`ifndef NFHC_REGS_SVH
`define NFHC_REGS_SVH
`define NFHC_CMD_READ_A      8'h00
`define NFHC_CMD_READ_B      8'h01
`define NFHC_CMD_READ_SPARE  8'h50
`define NFHC_CMD_READ_ID     8'h90
`define NFHC_CMD_RESET       8'hFF
`define NFHC_CMD_STATUS      8'h70
`define NFHC_CMD_LOCK        8'h2A
`define NFHC_CMD_LOCK_TIGHT  8'h2C
`define NFHC_CMD_LOCK_STATUS 8'h7A
`define NFHC_CMD_PROG        8'h80
`define NFHC_CMD_PROG_GO     8'h10
`define NFHC_CMD_COPY_GO     8'h8A
`define NFHC_CMD_ERASE       8'h60
`define NFHC_CMD_ERASE_GO    8'hD0
`define NFHC_CMD_UNLOCK      8'h23
`define NFHC_CMD_UNLOCK_GO   8'h24
// strobe phase length in ns and in cycles of the 4 ns clock
`define NFHC_PHASE_NS        28
`define NFHC_CLK_NS          4
`define NFHC_PHASE_CYC       ((`NFHC_PHASE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`define NFHC_CNT_W           4
`define NFHC_LAST_COL        10'h20F
`endif

// file: inc/nfhc_pkg.sv
// types of the nand host controller
package nfhc_pkg;
  typedef enum logic [2:0] {
    NFHC_OP_CMD  = 3'h0,
    NFHC_OP_ADDR = 3'h1,
    NFHC_OP_WR   = 3'h2,
    NFHC_OP_RD   = 3'h3,
    NFHC_OP_WAIT = 3'h4
  } nfhc_op_t;
  typedef struct packed {
    nfhc_op_t    op;
    logic [15:0] data;
  } nfhc_req_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic rd_n;
  } nfhc_strb_t;
  typedef enum logic [2:0] {
    NFHC_S_IDLE  = 3'h0,
    NFHC_S_LOW   = 3'h1,
    NFHC_S_HIGH  = 3'h2,
    NFHC_S_WAIT  = 3'h3,
    NFHC_S_DONE  = 3'h4
  } nfhc_state_t;
endpackage : nfhc_pkg

// file: testbench/nfhc_host_chk.sv
// pin protocol assertions for the nand host controller
`timescale 1ns/1ps
`default_nettype none
module nfhc_host_chk (
  input wire logic                I_CLK, I_RST, i_req_valid, i_write_protect_n,
  input wire logic                i_lock_autoread_enable, I_RB_N, o_req_ready, o_req_reject,
  input wire nfhc_pkg::nfhc_req_t i_req,
  input wire logic [15:0]         O_IO,
  input wire logic                o_busy, o_rd_valid, O_IO_OE, O_CLE, O_ALE, O_CE_N, O_WE_N,
  input wire logic                O_READ_STROBE_N, O_WP_N, O_LOCK_AUTOREAD_ENABLE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // ====
  // strobe phases
  sequence low_phase_s(s); (!s)[*6] ##1 s; endsequence
  wire take_cmd = i_req_valid && o_req_ready && i_req.op == nfhc_pkg::NFHC_OP_CMD;
  // ====
  // checks
  we_pulse_a: assert property ($fell(O_WE_N) |=> low_phase_s(O_WE_N)) else $error("write strobe width");
  rd_pulse_a: assert property ($fell(O_READ_STROBE_N) |=> low_phase_s(O_READ_STROBE_N) ##0 o_rd_valid)
    else $error("read strobe width");
  we_select_a: assert property ($rose(O_WE_N) |-> !O_CE_N && O_IO_OE) else $error("write edge unselected");
  latch_excl_a: assert property (!(O_CLE && O_ALE)) else $error("both latches high");
  addr_upper_a: assert property (O_CLE || O_ALE |-> O_IO[15:8] == 8'h00) else $error("upper lines set");
  busy_gate_a: assert property (take_cmd && !$past(I_RB_N, 2) && !(i_req.data[7:0] inside {8'hFF, 8'h70})
    |-> ##[1:2] o_req_reject) else $error("command taken while busy");
  wp_gate_a: assert property (take_cmd && !i_write_protect_n && i_req.data[7:0] inside {8'h10, 8'hD0, 8'h8A}
    |-> ##[1:2] o_req_reject) else $error("confirm taken while protected");
  busy_sync_a: assert property ($fell(I_RB_N) |-> ##[1:4] o_busy) else $error("busy not reported");
  mode_copy_a: assert property (!$past(I_RST) |-> O_LOCK_AUTOREAD_ENABLE == $past(i_lock_autoread_enable)
    && O_WP_N == $past(i_write_protect_n)) else $error("mode pins not copied");
endmodule : nfhc_host_chk
`default_nettype wire

// file: testbench/nfhc_dev_model.sv
// behavioural nand device on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module nfhc_dev_model #(parameter int BUSY_NS = 400) (
  input wire logic        cle, ale, ce_n, we_n, rd_n,
  input wire logic [15:0] io_drv,
  output logic            rb_n,
  output logic [15:0]     io_out
);
  logic [7:0] cmd_reg = 8'h00;
  logic [9:0] col_reg = 10'h000;
  int         n_addr = 0;
  initial rb_n = 1'b1;
  initial io_out = 16'h0000;
  // open drain with pull-up, low while working
  task busy();
    // both busy edges land between clock edges
    fork begin #1 rb_n = 1'b0; #BUSY_NS rb_n = 1'b1; end join_none
  endtask : busy
  // ====
  // latch on the write strobe rising edge
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd_reg = io_drv[7:0];
      n_addr = (io_drv[7:0] == 8'h60);
      col_reg = {io_drv[7:0] == 8'h50, io_drv[7:0] == 8'h01, 8'h00};
      if (io_drv[7:0] inside {8'h10, 8'hD0, 8'h8A}) busy();
    end else if (!ce_n && ale && n_addr < 3) begin
      if (n_addr == 0) col_reg[7:0] = io_drv[7:0];
      n_addr++;
      if (n_addr == 3 && cmd_reg inside {8'h00, 8'h01, 8'h50}) busy();
    end
  end
  // ====
  // serial output, garbage once released
  always @(negedge rd_n) begin
    io_out = {6'h00, col_reg};
    col_reg++;
  end
  always @(posedge rd_n) #8 io_out = ~io_out;
endmodule : nfhc_dev_model
`default_nettype wire

// file: testbench/test_nfhc_host.sv
// self-checking bench for the nand host controller
`timescale 1ns/1ps
`default_nettype none
module test_nfhc_host;
  typedef struct packed {logic [3:0] op; logic [15:0] d; logic [3:0] rj; logic [15:0] e;} nfhc_row_t;
  logic                I_CLK = 1'b0, I_RST = 1'b1, i_req_valid = 1'b0, wp_n = 1'b1, lock = 1'b0, rj;
  logic [15:0]         rd;
  nfhc_pkg::nfhc_req_t i_req = '0;
  wire                 rb_n, ready, rej_p, rdv, oe, cle, ale, ce_n, we_n, rd_n, wpo, locko, busy_o;
  wire [15:0]          rdat, io_o, dev_io;
  wire [15:0]          io_w = oe ? io_o : dev_io;
  int                  fails = 0, samples_checked = 0, cycles = 0;
  // rows: op, data, reject, expected read word
  nfhc_row_t rows [36] = '{40'h0000000000, 40'h1000500000, 40'h1000100000, 40'h1000000000, 40'h1000710000,
    40'h4000000000, 40'h3000000005, 40'h3000000006, 40'h0000100000, 40'h1000200000, 40'h1000000000,
    40'h1000000000, 40'h4000000000, 40'h3000000102, 40'h0005000000, 40'h1000300000, 40'h1000000000,
    40'h1000000000, 40'h4000000000, 40'h3000000203, 40'h0008000000, 40'h1000000000, 40'h1000000000,
    40'h1000000000, 40'h2123400000, 40'h0001000000, 40'h0000010000, 40'h4000000000, 40'h0006000000,
    40'h1000100000, 40'h1000000000, 40'h000D000000, 40'h0007000000, 40'h1000010000, 40'h4000000000,
    40'h0003310000};
  logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h50, 8'h90, 8'hFF, 8'h70, 8'h2A, 8'h2C, 8'h7A, 8'h80,
    8'h10, 8'h8A, 8'h60, 8'hD0, 8'h23, 8'h24};
  nfhc_host uut (.I_CLK(I_CLK), .I_RST(I_RST), .i_req(i_req), .i_req_valid(i_req_valid),
    .i_lock_autoread_enable(lock), .i_write_protect_n(wp_n), .I_RB_N(rb_n), .I_IO(io_w),
    .o_req_ready(ready), .o_req_reject(rej_p), .o_rd_data(rdat), .o_rd_valid(rdv), .o_busy(busy_o),
    .O_IO(io_o), .O_IO_OE(oe), .O_CLE(cle), .O_ALE(ale), .O_CE_N(ce_n), .O_WE_N(we_n),
    .O_READ_STROBE_N(rd_n), .O_WP_N(wpo), .O_LOCK_AUTOREAD_ENABLE(locko));
  nfhc_dev_model dev (.cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .rd_n(rd_n), .io_drv(io_w),
    .rb_n(rb_n), .io_out(dev_io));
  always #2 I_CLK = ~I_CLK;
  // ====
  // tasks
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin fails++; $display("MISMATCH %s expected %b seen %b", nm, e, g); end
  endtask : chk_bit
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin fails++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end
  endtask : chk_word
  task automatic req(input logic [2:0] op, input logic [15:0] d, output logic r, output logic [15:0] q);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 600) begin @(negedge I_CLK); n++; end
    i_req = '{nfhc_pkg::nfhc_op_t'(op), d};
    i_req_valid = 1'b1;
    @(negedge I_CLK);
    i_req_valid = 1'b0;
    r = rej_p;
    q = 16'hXXXX;
    do begin
      @(negedge I_CLK);
      n++;
      r = r | rej_p;
      if (rdv === 1'b1) q = rdat;
    end while (ready !== 1'b1 && n < 1200);
    if (ready !== 1'b1) begin fails++; wrap_up(); end
  endtask : req
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 20000) begin fails++; wrap_up(); end
  end
  // ====
  // main sequence
  initial begin
    repeat (12) @(negedge I_CLK);
    chk_bit("chip select in reset", 1'b1, ce_n);
    chk_bit("protect in reset", 1'b0, wpo);
    I_RST = 1'b0;
    @(negedge I_CLK);
    foreach (rows[i]) begin
      req(rows[i].op[2:0], rows[i].d, rj, rd);
      chk_bit("reject", rows[i].rj[0], rj);
      if (rows[i].op == 4'h3) chk_word("read word", rows[i].e, rd);
    end
    foreach (codes[i]) begin
      req(3'h0, {8'h00, codes[i]}, rj, rd);
      chk_bit("legal command", 1'b0, rj);
      chk_bit("busy flag", codes[i] inside {8'h10, 8'h8A, 8'hD0}, busy_o);
      req(3'h4, 16'h0000, rj, rd);
      chk_bit("busy after wait", 1'b0, busy_o);
    end
    // reset in the middle of a write strobe
    i_req = '{nfhc_pkg::NFHC_OP_CMD, 16'h0080};
    i_req_valid = 1'b1;
    @(negedge I_CLK);
    i_req_valid = 1'b0;
    repeat (3) @(negedge I_CLK);
    I_RST = 1'b1;
    repeat (2) @(negedge I_CLK);
    chk_bit("write strobe mid reset", 1'b1, we_n);
    chk_bit("chip select mid reset", 1'b1, ce_n);
    chk_bit("ready mid reset", 1'b0, ready);
    I_RST = 1'b0;
    @(negedge I_CLK);
    chk_bit("ready after reset", 1'b1, ready);
    chk_bit("latch after reset", 1'b0, cle);
    wp_n = 1'b0;
    lock = 1'b1;
    req(3'h0, 16'h0010, rj, rd);
    chk_bit("protected confirm", 1'b1, rj);
    chk_bit("protect pin", 1'b0, wpo);
    chk_bit("lock pin", 1'b1, locko);
    wrap_up();
  end
endmodule : test_nfhc_host
bind nfhc_host nfhc_host_chk chk (.I_CLK(I_CLK), .I_RST(I_RST), .i_req_valid(i_req_valid),
  .i_write_protect_n(i_write_protect_n), .i_lock_autoread_enable(i_lock_autoread_enable), .I_RB_N(I_RB_N),
  .o_req_ready(o_req_ready), .o_req_reject(o_req_reject), .i_req(i_req), .O_IO(O_IO), .o_busy(o_busy),
  .o_rd_valid(o_rd_valid), .O_IO_OE(O_IO_OE), .O_CLE(O_CLE), .O_ALE(O_ALE), .O_CE_N(O_CE_N), .O_WE_N(O_WE_N),
  .O_READ_STROBE_N(O_READ_STROBE_N), .O_WP_N(O_WP_N), .O_LOCK_AUTOREAD_ENABLE(O_LOCK_AUTOREAD_ENABLE));
`default_nettype wire
